/* File: pmicps_ctrl.sv */
module pmicps_ctrl
  import pmicps_pkg::*;
#(
  parameter int TICK_DIVIDE = int'(pmicps_pkg::TICK_DIV),
  parameter int SHORT_TICKS = int'(pmicps_pkg::DBNC_SHORT_TICKS),
  parameter int MID_TICKS = int'(pmicps_pkg::DBNC_MID_TICKS),
  parameter int LONG_TICKS = int'(pmicps_pkg::DBNC_LONG_TICKS),
  parameter int PRESS_TICKS = int'(pmicps_pkg::LONG_PRESS_TICKS)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pmicps_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pmicps_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pmicps_pkg::DATA_W-1:0] reg_rdata,
  input wire logic power_on_input,
  input wire logic standby_input,
  input wire logic vin_above_uv,
  input wire logic thermal_shutdown,
  input wire logic [pmicps_pkg::NUM_FAULT-1:0] fault_event,
  output logic host_reset_output_n,
  output logic interrupt_output_n,
  output logic [pmicps_pkg::NUM_REG-1:0] reg_enable,
  output logic [pmicps_pkg::NUM_REG-1:0] reg_pfm,
  output logic sleep_setpoint_sel,
  output logic [5:0] pair_one_sleep_vsel,
  output logic [6:0] buck_two_sleep_vsel,
  output logic [6:0] buck_pair_three_sleep_vsel,
  output pmicps_pkg::pmicps_state_t power_state
);
  import pmicps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // 32 kHz tick divider
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_tick = 1'b0;
    if (div_ff == DIV_W'(TICK_DIVIDE - 1)) begin
      nxt_div = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_div = div_ff + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on input synchroniser and hold counter
  logic pon_s1_ff, pon_s2_ff, pon_prev_ff;
  logic [CNT_W-1:0] hold_ff, nxt_hold;
  logic pon_change;

  assign pon_change = pon_s2_ff != pon_prev_ff;

  always_comb begin
    nxt_hold = hold_ff;
    if (pon_change) begin
      nxt_hold = '0;
    end else if (tick_ff && hold_ff != CNT_W'(PRESS_TICKS)) begin
      nxt_hold = hold_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pon_s1_ff <= 1'b0;
      pon_s2_ff <= 1'b0;
      pon_prev_ff <= 1'b0;
      hold_ff <= '0;
    end else begin
      pon_s1_ff <= power_on_input;
      pon_s2_ff <= pon_s1_ff;
      pon_prev_ff <= pon_s2_ff;
      hold_ff <= nxt_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [NUM_REG-1:0] keep_ff, nxt_keep;
  logic [5:0] p1_sleep_ff, nxt_p1_sleep;
  logic [6:0] b2_sleep_ff, nxt_b2_sleep;
  logic [6:0] p3_sleep_ff, nxt_p3_sleep;
  logic [NUM_FAULT-1:0] mask_ff, nxt_mask;
  logic btn_mode, long_en, restart_en;
  logic [1:0] dbnc_sel;

  assign btn_mode = ctrl_ff[CTRL_BTN_POS];
  assign dbnc_sel = ctrl_ff[CTRL_DBNC_POS +: 2];
  assign long_en = ctrl_ff[CTRL_LONG_POS];
  assign restart_en = ctrl_ff[CTRL_RESTART_POS];

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_keep = keep_ff;
    nxt_p1_sleep = p1_sleep_ff;
    nxt_b2_sleep = b2_sleep_ff;
    nxt_p3_sleep = p3_sleep_ff;
    nxt_mask = mask_ff;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL: nxt_ctrl = reg_wdata[CTRL_W-1:0];
        OFS_KEEP: nxt_keep = reg_wdata[NUM_REG-1:0];
        OFS_P1_SLEEP: nxt_p1_sleep = reg_wdata[5:0];
        OFS_B2_SLEEP: nxt_b2_sleep = reg_wdata[6:0];
        OFS_P3_SLEEP: nxt_p3_sleep = reg_wdata[6:0];
        OFS_MASK: nxt_mask = reg_wdata[NUM_FAULT-1:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  // Coin-cell power-on reset returns every bit to its default
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
      keep_ff <= KEEP_RST;
      p1_sleep_ff <= P1_SLEEP_RST;
      b2_sleep_ff <= B2_SLEEP_RST;
      p3_sleep_ff <= P3_SLEEP_RST;
      mask_ff <= MASK_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      keep_ff <= nxt_keep;
      p1_sleep_ff <= nxt_p1_sleep;
      b2_sleep_ff <= nxt_b2_sleep;
      p3_sleep_ff <= nxt_p3_sleep;
      mask_ff <= nxt_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debounced events
  logic [CNT_W-1:0] fall_ticks;
  logic on_press, fall_evt, rise_evt, long_evt;

  always_comb begin
    unique case (dbnc_sel)
      2'b00: fall_ticks = CNT_W'(SHORT_TICKS);
      2'b01: fall_ticks = CNT_W'(SHORT_TICKS);
      2'b10: fall_ticks = CNT_W'(MID_TICKS);
      2'b11: fall_ticks = CNT_W'(LONG_TICKS);
    endcase
  end

  // Turn-on fires at the edge for select 00, else with the falling debounce
  assign on_press = (dbnc_sel == 2'b00) ? (pon_change && !pon_s2_ff) : fall_evt;
  assign fall_evt = tick_ff && !pon_change && !pon_s2_ff && hold_ff == fall_ticks - CNT_W'(1);
  assign rise_evt = tick_ff && !pon_change && pon_s2_ff
                    && hold_ff == CNT_W'(SHORT_TICKS - 1);
  assign long_evt = tick_ff && !pon_change && !pon_s2_ff
                    && hold_ff == CNT_W'(PRESS_TICKS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine
  pmicps_state_t state_ff, nxt_state;
  logic restart_ff, nxt_restart;
  logic turn_on, level_off, any_keep, stby_req;
  logic [NUM_REG-1:0] sleep_keep_ff, nxt_sleep_keep;
  logic [5:0] p1_hold_ff, nxt_p1_hold;
  logic [6:0] b2_hold_ff, nxt_b2_hold;
  logic [6:0] p3_hold_ff, nxt_p3_hold;

  assign any_keep = |keep_ff;
  assign stby_req = standby_input ^ ctrl_ff[CTRL_STBYINV_POS];
  assign level_off = !btn_mode && !pon_s2_ff;
  // Level mode covers the supply rising with the input already high
  assign turn_on = vin_above_uv && !thermal_shutdown
                   && (btn_mode ? (on_press || restart_ff) : (pon_s2_ff || restart_ff));

  always_comb begin
    nxt_state = state_ff;
    nxt_restart = restart_ff;
    if (!vin_above_uv) begin
      nxt_state = ST_COIN;
      nxt_restart = 1'b0;
    end else begin
      unique case (state_ff)
        ST_COIN: begin
          nxt_state = ST_OFF;
        end
        ST_OFF: begin
          if (turn_on) begin
            nxt_state = ST_ON;
            nxt_restart = 1'b0;
          end
        end
        ST_SLEEP: begin
          if (thermal_shutdown) begin
            nxt_state = ST_OFF;
          end else if (btn_mode && long_en && long_evt) begin
            nxt_state = ST_OFF;
            nxt_restart = restart_en;
          end else if (turn_on) begin
            nxt_state = ST_ON;
          end
        end
        ST_STBY, ST_ON: begin
          if (thermal_shutdown) begin
            nxt_state = ST_OFF;
          end else if (level_off) begin
            nxt_state = any_keep ? ST_SLEEP : ST_OFF;
          end else if (btn_mode && long_en && long_evt) begin
            nxt_state = any_keep ? ST_SLEEP : ST_OFF;
            nxt_restart = !any_keep && restart_en;
          end else if (state_ff == ST_ON && stby_req) begin
            nxt_state = ST_STBY;
          end else if (state_ff == ST_STBY && !stby_req) begin
            nxt_state = ST_ON;
          end
        end
      endcase
    end
  end

  // Sleep configuration captured on entry and frozen while asleep
  always_comb begin
    nxt_sleep_keep = sleep_keep_ff;
    nxt_p1_hold = p1_hold_ff;
    nxt_b2_hold = b2_hold_ff;
    nxt_p3_hold = p3_hold_ff;
    if (nxt_state == ST_SLEEP && state_ff != ST_SLEEP) begin
      nxt_sleep_keep = keep_ff;
      nxt_p1_hold = p1_sleep_ff;
      nxt_b2_hold = b2_sleep_ff;
      nxt_p3_hold = p3_sleep_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_COIN;
      restart_ff <= 1'b0;
      sleep_keep_ff <= KEEP_RST;
      p1_hold_ff <= P1_SLEEP_RST;
      b2_hold_ff <= B2_SLEEP_RST;
      p3_hold_ff <= P3_SLEEP_RST;
    end else begin
      state_ff <= nxt_state;
      restart_ff <= nxt_restart;
      sleep_keep_ff <= nxt_sleep_keep;
      p1_hold_ff <= nxt_p1_hold;
      b2_hold_ff <= nxt_b2_hold;
      p3_hold_ff <= nxt_p3_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags
  logic pon_irq_ff, nxt_pon_irq;
  logic [NUM_FAULT-1:0] fault_ff, nxt_fault;
  logic irq_live, pon_set, clr_wr;

  assign irq_live = state_ff == ST_SLEEP || state_ff == ST_STBY || state_ff == ST_ON;
  assign clr_wr = reg_wr && reg_addr == OFS_IRQ;
  assign pon_set = btn_mode ? (fall_evt || rise_evt)
                   : (nxt_state == ST_ON && (state_ff == ST_OFF || state_ff == ST_SLEEP));

  always_comb begin
    nxt_pon_irq = pon_irq_ff;
    nxt_fault = fault_ff;
    if (clr_wr) begin
      nxt_pon_irq = pon_irq_ff & ~reg_wdata[IRQ_PON_POS];
      nxt_fault = fault_ff & ~reg_wdata[IRQ_FAULT_POS +: NUM_FAULT];
    end
    if (state_ff == ST_OFF) begin
      nxt_pon_irq = 1'b0;
    end
    if (pon_set && state_ff != ST_COIN) begin
      nxt_pon_irq = 1'b1;
    end
    if (irq_live) begin
      nxt_fault = nxt_fault | fault_event;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pon_irq_ff <= 1'b0;
      fault_ff <= '0;
    end else begin
      pon_irq_ff <= nxt_pon_irq;
      fault_ff <= nxt_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic host_rst_n_ff, nxt_host_rst_n;
  logic irq_n_ff, nxt_irq_n;
  logic [NUM_REG-1:0] en_ff, nxt_en;
  logic [NUM_REG-1:0] pfm_ff, nxt_pfm;

  always_comb begin
    nxt_host_rst_n = nxt_state == ST_ON || nxt_state == ST_STBY;
    nxt_irq_n = !(irq_live && (pon_irq_ff || |(fault_ff & ~mask_ff)));
    nxt_en = '0;
    nxt_pfm = '0;
    unique case (nxt_state)
      ST_ON, ST_STBY: nxt_en = '1;
      ST_SLEEP: begin
        nxt_en = nxt_sleep_keep;
        nxt_pfm = nxt_sleep_keep;
      end
      ST_OFF, ST_COIN: nxt_en = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rst_n_ff <= 1'b0;
      irq_n_ff <= 1'b1;
      en_ff <= '0;
      pfm_ff <= '0;
    end else begin
      host_rst_n_ff <= nxt_host_rst_n;
      irq_n_ff <= nxt_irq_n;
      en_ff <= nxt_en;
      pfm_ff <= nxt_pfm;
    end
  end

  assign host_reset_output_n = host_rst_n_ff;
  assign interrupt_output_n = irq_n_ff;
  assign reg_enable = en_ff;
  assign reg_pfm = pfm_ff;
  assign sleep_setpoint_sel = state_ff == ST_SLEEP;
  assign pair_one_sleep_vsel = p1_hold_ff;
  assign buck_two_sleep_vsel = b2_hold_ff;
  assign buck_pair_three_sleep_vsel = p3_hold_ff;
  assign power_state = state_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL: nxt_rdata[CTRL_W-1:0] = ctrl_ff;
        OFS_KEEP: nxt_rdata[NUM_REG-1:0] = keep_ff;
        OFS_P1_SLEEP: nxt_rdata[5:0] = p1_sleep_ff;
        OFS_B2_SLEEP: nxt_rdata[6:0] = b2_sleep_ff;
        OFS_P3_SLEEP: nxt_rdata[6:0] = p3_sleep_ff;
        OFS_STATUS: begin
          nxt_rdata[STAT_SENSE_POS] = pon_s2_ff;
          nxt_rdata[STAT_STATE_POS +: 5] = state_ff;
        end
        OFS_IRQ: begin
          nxt_rdata[IRQ_PON_POS] = pon_irq_ff;
          nxt_rdata[IRQ_FAULT_POS +: NUM_FAULT] = fault_ff;
        end
        OFS_MASK: nxt_rdata[NUM_FAULT-1:0] = mask_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule

/* File: pmicps_ctrl_monitor.sv */
module pmicps_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vin_above_uv,
  input wire logic thermal_shutdown,
  input wire logic host_reset_output_n,
  input wire logic interrupt_output_n,
  input wire logic [pmicps_pkg::NUM_REG-1:0] reg_enable,
  input wire logic [pmicps_pkg::NUM_REG-1:0] reg_pfm,
  input wire logic sleep_setpoint_sel,
  input wire logic [5:0] pair_one_sleep_vsel,
  input wire logic [6:0] buck_two_sleep_vsel,
  input wire logic [6:0] buck_pair_three_sleep_vsel,
  input wire pmicps_pkg::pmicps_state_t power_state
);
  timeunit 1ns;
  timeprecision 100ps;
  import pmicps_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_sleep_held;
    (power_state == ST_SLEEP) [*2];
  endsequence

  sequence s_sleep_to_on;
    (power_state == ST_SLEEP) ##1 (power_state == ST_ON);
  endsequence

  ////////////////////////////////////////////////////////////
  host_on_high_a: assert property (power_state == ST_ON |-> host_reset_output_n)
    else $error("host reset low in on state");
  host_off_low_a: assert property (power_state inside {ST_OFF, ST_COIN} |-> !host_reset_output_n)
    else $error("host reset released in off or coin state");
  uv_to_coin_a: assert property (!vin_above_uv |=> power_state == ST_COIN)
    else $error("supply loss did not reach coin state");
  coin_exit_a: assert property (power_state == ST_COIN |=> power_state inside {ST_COIN, ST_OFF})
    else $error("coin state left for other than off");
  thermal_off_a: assert property (
    thermal_shutdown && vin_above_uv && power_state inside {ST_ON, ST_STBY, ST_SLEEP} |=> power_state == ST_OFF)
    else $error("thermal shutdown did not force off");
  thermal_hold_a: assert property (power_state == ST_OFF && thermal_shutdown |=> power_state != ST_ON)
    else $error("turned on during thermal shutdown");
  sleep_point_a: assert property (sleep_setpoint_sel == (power_state == ST_SLEEP))
    else $error("sleep set point select wrong");
  sleep_pfm_a: assert property (reg_pfm == ((power_state == ST_SLEEP) ? reg_enable : 3'h0))
    else $error("pfm drive does not match sleep keep");
  sleep_freeze_a: assert property (
    s_sleep_held |-> $stable(pair_one_sleep_vsel) && $stable(buck_two_sleep_vsel)
      && $stable(buck_pair_three_sleep_vsel))
    else $error("sleep set point changed during sleep");
  kept_on_a: assert property (s_sleep_to_on |-> ($past(reg_enable) & ~reg_enable) == 3'h0)
    else $error("kept regulator dropped on sleep exit");
  irq_idle_a: assert property ((power_state inside {ST_COIN, ST_OFF}) [*2] |-> interrupt_output_n)
    else $error("interrupt active outside active states");
endmodule

bind pmicps_ctrl pmicps_monitor u_monitor (.clk(clk), .rst_n(rst_n), .vin_above_uv(vin_above_uv),
  .thermal_shutdown(thermal_shutdown), .host_reset_output_n(host_reset_output_n),
  .interrupt_output_n(interrupt_output_n), .reg_enable(reg_enable), .reg_pfm(reg_pfm),
  .sleep_setpoint_sel(sleep_setpoint_sel), .pair_one_sleep_vsel(pair_one_sleep_vsel),
  .buck_two_sleep_vsel(buck_two_sleep_vsel), .buck_pair_three_sleep_vsel(buck_pair_three_sleep_vsel),
  .power_state(power_state));

/* File: pmicps_ctrl_tb.sv */
module pmicps_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pmicps_pkg::*;

  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} pmicps_row_t;
  localparam int TD = 4;
  localparam int PRESS = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pin_cmd = 1'b0;
  logic stby_cmd = 1'b0;
  logic chatter = 1'b0;
  logic vin_above_uv = 1'b1;
  logic thermal_shutdown = 1'b0;
  logic [3:0] fault_event = 4'h0;
  logic [31:0] reg_rdata, rd_data;
  logic power_on_input, standby_input, host_reset_output_n, interrupt_output_n, sleep_sel;
  logic [2:0] reg_enable, reg_pfm;
  logic [5:0] p1_vsel;
  logic [6:0] b2_vsel, p3_vsel;
  pmicps_state_t power_state;
  int miscompares = 0;
  int samples_checked = 0;
  pmicps_row_t rows [8] = '{'{OFS_CTRL, 32'hffffff2e, 32'h2e}, '{OFS_KEEP, 32'hffffffff, 32'h7},
    '{OFS_P1_SLEEP, 32'hffffffff, 32'h3f}, '{OFS_B2_SLEEP, 32'h000000aa, 32'h2a},
    '{OFS_P3_SLEEP, 32'hffffff81, 32'h01}, '{OFS_MASK, 32'h00000005, 32'h5},
    '{OFS_STATUS, 32'h0000ffff, 32'h4}, '{8'h20, 32'hffffffff, 32'h0}};

  always #2 clk = ~clk;

  pmicps_host_model u_host (.clk(clk), .pin_cmd(pin_cmd), .stby_cmd(stby_cmd), .chatter(chatter),
    .power_on_input(power_on_input), .standby_input(standby_input));

  pmicps_ctrl #(.TICK_DIVIDE(TD), .SHORT_TICKS(4), .MID_TICKS(8), .LONG_TICKS(12), .PRESS_TICKS(PRESS)) uut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_on_input(power_on_input), .standby_input(standby_input),
    .vin_above_uv(vin_above_uv), .thermal_shutdown(thermal_shutdown), .fault_event(fault_event),
    .host_reset_output_n(host_reset_output_n), .interrupt_output_n(interrupt_output_n),
    .reg_enable(reg_enable), .reg_pfm(reg_pfm), .sleep_setpoint_sel(sleep_sel),
    .pair_one_sleep_vsel(p1_vsel), .buck_two_sleep_vsel(b2_vsel), .buck_pair_three_sleep_vsel(p3_vsel),
    .power_state(power_state));

  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_data = reg_rdata;
  endtask

  task automatic pin(input logic v);
    @(posedge clk);
    pin_cmd <= v;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Polls once per clock, so a single-cycle visit is still seen
  task automatic wait_st(input pmicps_state_t exp, input int lim);
    #1;
    for (int i = 0; i < lim && power_state !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    samples_checked++;
    if (power_state !== exp) begin
      miscompares++;
      $display("[FAIL] power_state expected %b seen %b", exp, power_state);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches %0d", name, miscompares);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    #40000;
    miscompares++;
    $display("[FAIL] watchdog expected finish seen hang");
    give_verdict;
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_st(ST_OFF, 4);
    check("host reset", 32'h0, {31'h0, host_reset_output_n});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      check("register readback", rows[i].e, rd_data);
    end
    end_test("registers");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_KEEP, 32'h0);
    wr(OFS_MASK, 32'hf);
    pin(1'b1);
    wait_st(ST_ON, 10);
    rd(OFS_STATUS);
    check("status", 32'h21, rd_data);
    rd(OFS_IRQ);
    check("turn-on irq", 32'h1, rd_data);
    pin(1'b0);
    wait_st(ST_OFF, 10);
    rd(OFS_IRQ);
    check("irq after off", 32'h0, rd_data);
    pin(1'b1);
    wait_st(ST_ON, 10);
    wr(OFS_IRQ, 32'h1);
    rd(OFS_IRQ);
    check("irq cleared", 32'h0, rd_data);
    end_test("level");
    @(posedge clk) stby_cmd <= 1'b1;
    wait_st(ST_STBY, 10);
    wr(OFS_CTRL, 32'h20);
    wait_st(ST_ON, 10);
    @(posedge clk) stby_cmd <= 1'b0;
    wait_st(ST_STBY, 10);
    wr(OFS_CTRL, 32'h0);
    wait_st(ST_ON, 10);
    end_test("standby");
    wr(OFS_KEEP, 32'h5);
    wr(OFS_P1_SLEEP, 32'h15);
    wr(OFS_B2_SLEEP, 32'h2a);
    wr(OFS_P3_SLEEP, 32'h6c);
    wr(OFS_MASK, 32'h0);
    pin(1'b0);
    wait_st(ST_SLEEP, 10);
    check("sleep enables", 32'h5, {29'h0, reg_enable});
    check("sleep pfm", 32'h5, {29'h0, reg_pfm});
    wr(OFS_B2_SLEEP, 32'h11);
    check("sleep set points", {12'h0, 6'h15, 7'h2a, 7'h6c}, {12'h0, p1_vsel, b2_vsel, p3_vsel});
    @(posedge clk) fault_event <= 4'h4;
    @(posedge clk) fault_event <= 4'h0;
    repeat (3) @(posedge clk);
    #1 check("interrupt pin", 32'h0, {31'h0, interrupt_output_n});
    rd(OFS_IRQ);
    check("fault flag", 32'h8, rd_data);
    wr(OFS_IRQ, 32'h1f);
    wr(OFS_MASK, 32'hf);
    pin(1'b1);
    wait_st(ST_ON, 10);
    check("kept enables", 32'h5, {29'h0, reg_enable & 3'h5});
    end_test("sleep");
    wr(OFS_KEEP, 32'h0);
    @(posedge clk) thermal_shutdown <= 1'b1;
    wait_st(ST_OFF, 5);
    repeat (20) @(posedge clk);
    wait_st(ST_OFF, 0);
    @(posedge clk) thermal_shutdown <= 1'b0;
    wait_st(ST_ON, 10);
    @(posedge clk) vin_above_uv <= 1'b0;
    wait_st(ST_COIN, 3);
    check("coin host reset", 32'h0, {31'h0, host_reset_output_n});
    repeat (20) @(posedge clk);
    wait_st(ST_COIN, 0);
    @(posedge clk) vin_above_uv <= 1'b1;
    wait_st(ST_OFF, 3);
    wait_st(ST_ON, 10);
    end_test("protection");
    wr(OFS_CTRL, 32'h0b);
    wr(OFS_IRQ, 32'h1);
    pin(1'b0);
    repeat (28) @(posedge clk);
    rd(OFS_IRQ);
    check("falling irq", 32'h1, rd_data);
    wait_st(ST_OFF, TD * PRESS + 20);
    pin(1'b1);
    repeat (40) @(posedge clk);
    wait_st(ST_OFF, 0);
    wr(OFS_CTRL, 32'h0f);
    pin(1'b0);
    repeat (30) @(posedge clk);
    pin(1'b1);
    repeat (20) @(posedge clk);
    wait_st(ST_OFF, 0);
    wr(OFS_CTRL, 32'h0b);
    @(posedge clk) chatter <= 1'b1;
    repeat (40) @(posedge clk);
    chatter <= 1'b0;
    repeat (20) @(posedge clk);
    wait_st(ST_OFF, 0);
    pin(1'b0);
    wait_st(ST_ON, 40);
    wr(OFS_IRQ, 32'h1);
    pin(1'b1);
    repeat (30) @(posedge clk);
    rd(OFS_IRQ);
    check("rising irq", 32'h1, rd_data);
    wr(OFS_CTRL, 32'h1b);
    pin(1'b0);
    wait_st(ST_OFF, 120);
    wait_st(ST_ON, 10);
    pin(1'b1);
    end_test("button");
    @(posedge clk) thermal_shutdown <= 1'b1;
    wait_st(ST_OFF, 5);
    @(posedge clk) thermal_shutdown <= 1'b0;
    // Select 10: a press longer than the short debounce must not turn on
    wr(OFS_CTRL, 32'h05);
    pin(1'b0);
    repeat (24) @(posedge clk);
    pin(1'b1);
    repeat (20) @(posedge clk);
    wait_st(ST_OFF, 0);
    // Select 00: turn-on follows the synchronised edge, no debounce
    wr(OFS_CTRL, 32'h01);
    pin(1'b0);
    wait_st(ST_ON, 6);
    pin(1'b1);
    end_test("debounce");
    @(posedge clk) rst_n <= 1'b0;
    wait_st(ST_COIN, 2);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CTRL);
    check("ctrl default", 32'h0, rd_data);
    rd(OFS_KEEP);
    check("keep default", 32'h0, rd_data);
    rd(OFS_MASK);
    check("mask default", 32'hf, rd_data);
    end_test("reset");
    give_verdict;
  end
endmodule

/* File: pmicps_host_model.sv */
module pmicps_host_model (
  input wire logic clk,
  input wire logic pin_cmd,
  input wire logic stby_cmd,
  input wire logic chatter,
  output logic power_on_input,
  output logic standby_input
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    power_on_input = 1'b0;
    standby_input = 1'b0;
  end

  // Pin follows command a clock later; chatter toggles it every clock
  always @(posedge clk) begin
    power_on_input <= chatter ? ~power_on_input : pin_cmd;
    standby_input <= stby_cmd;
  end
endmodule

/* File: pmicps_pkg.sv */
package pmicps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_REG = 3;
  localparam int NUM_FAULT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEEP = 8'h04;
  localparam logic [7:0] OFS_P1_SLEEP = 8'h08;
  localparam logic [7:0] OFS_B2_SLEEP = 8'h0c;
  localparam logic [7:0] OFS_P3_SLEEP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_BTN_POS = 0;
  localparam int CTRL_DBNC_POS = 1;
  localparam int CTRL_LONG_POS = 3;
  localparam int CTRL_RESTART_POS = 4;
  localparam int CTRL_STBYINV_POS = 5;
  localparam int CTRL_W = 6;

  // Status register fields
  localparam int STAT_SENSE_POS = 0;
  localparam int STAT_STATE_POS = 1;

  // Interrupt register fields
  localparam int IRQ_PON_POS = 0;
  localparam int IRQ_FAULT_POS = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [2:0] KEEP_RST = 3'h0;
  localparam logic [5:0] P1_SLEEP_RST = 6'h00;
  localparam logic [6:0] B2_SLEEP_RST = 7'h00;
  localparam logic [6:0] P3_SLEEP_RST = 7'h00;
  localparam logic [3:0] MASK_RST = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: clock rates and times in microseconds
  localparam longint CLK_HZ = 250000000;
  localparam longint SLOW_HZ = 32768;
  localparam longint TICK_DIV = CLK_HZ / SLOW_HZ;
  localparam longint DBNC_SHORT_US = 31250;
  localparam longint DBNC_MID_US = 125000;
  localparam longint DBNC_LONG_US = 750000;
  localparam longint LONG_PRESS_US = 4000000;
  localparam longint DBNC_SHORT_TICKS = (DBNC_SHORT_US * SLOW_HZ + 999999) / 1000000;
  localparam longint DBNC_MID_TICKS = (DBNC_MID_US * SLOW_HZ + 999999) / 1000000;
  localparam longint DBNC_LONG_TICKS = (DBNC_LONG_US * SLOW_HZ + 999999) / 1000000;
  localparam longint LONG_PRESS_TICKS = (LONG_PRESS_US * SLOW_HZ + 999999) / 1000000;
  localparam int CNT_W = 18;
  localparam int DIV_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Power states
  typedef enum logic [4:0] {
    ST_COIN = 5'b00001,
    ST_OFF = 5'b00010,
    ST_SLEEP = 5'b00100,
    ST_STBY = 5'b01000,
    ST_ON = 5'b10000
  } pmicps_state_t;

endpackage
